// [dv/tsr_master.sv]
`default_nettype none
// ==========================================
// Serial bus master model; data line has a pull-up
module tsr_master (
  input wire logic dev_sda_i,
  input wire logic dev_oe_n_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Half period of the serial clock; device needs 8 clocks a phase
  localparam int HP = 80;
  logic drive_low;
  assign sda_o = (dev_oe_n_i ? 1'b1 : dev_sda_i) & !drive_low;
  initial begin
    scl_o = 1'b1;
    drive_low = 1'b0;
  end
  task automatic bitx(input logic b, output logic s);
    #(HP / 4);
    drive_low = !b;
    #(HP - HP / 4);
    scl_o = 1'b1;
    #(HP / 2);
    s = sda_o;
    #(HP / 2);
    scl_o = 1'b0;
  endtask
  task automatic start();
    // Odd offset keeps pin edges off the system clock edge
    #(HP / 4 + 3);
    drive_low = 1'b0;
    #(HP - HP / 4);
    scl_o = 1'b1;
    #HP;
    drive_low = 1'b1;
    #HP;
    scl_o = 1'b0;
  endtask
  task automatic stop();
    #(HP / 4);
    drive_low = 1'b1;
    #(HP - HP / 4);
    scl_o = 1'b1;
    #HP;
    drive_low = 1'b0;
    #HP;
  endtask
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(v[i], s);
    end
    bitx(1'b1, s);
    ack = !s;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, v[i]);
    end
    bitx(!ack, s);
  endtask
endmodule // tsr_master
`default_nettype wire

// [dv/tsr_top_tb.sv]
`include "tsr_consts.svh"
`default_nettype none
module tsr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] strap = 2'h0;
  logic [12:0] cdata = 13'h0000;
  logic cvalid = 1'b0;
  logic scl, sda, sda_o, oe_n, req, shdn, alarm;
  int error_cnt = 0;
  int tests_run = 0;
  int req_cnt = 0;
  int mcfg, mhi, mlo, mtemp, mptr, ma, wu, cnt;
  int dep[4] = '{1, 2, 4, 6};
  always #5 clk = !clk;
  always @(posedge clk) if (req === 1'b1) req_cnt <= req_cnt + 1;
  tsr_top #(.CONV_CYCLES(200)) tsr_top_inst (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .SCL_I(scl), .SDA_I(sda), .ADDR_SEL_I(strap),
    .CONV_DATA_I(cdata), .CONV_VALID_I(cvalid), .SDA_O(sda_o), .SDA_OE_N_O(oe_n),
    .CONV_REQ_O(req), .SHUTDOWN_O(shdn), .OVERTEMP_ALARM_OUT_O(alarm)
  );
  tsr_master tsr_master_inst (.dev_sda_i(sda_o), .dev_oe_n_i(oe_n), .scl_o(scl), .sda_o(sda));
  // ==========================================
  // Checking and reference model
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic pin();
    chk({15'h0, alarm}, 16'(mcfg[2] ? ma : !ma));
  endtask
  function automatic int mreg(input int p);
    case (p)
      0: return mtemp;
      1: return mcfg;
      2: return mlo;
      default: return mhi;
    endcase
  endfunction
  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic do_rst(input logic [1:0] s);
    @(posedge clk);
    rst <= 1'b1;
    strap <= s;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    mcfg = 0;
    mhi = int'(`TSR_UPPER_TEMP_LIMIT_RST) << 7;
    mlo = int'(`TSR_LOWER_TEMP_LIMIT_RST) << 7;
    {mtemp, mptr, ma, wu, cnt} = '0;
    repeat (5) @(posedge clk);
    pin();
  endtask
  // ==========================================
  // Register access over the serial link
  task automatic reg_op(input int p, input logic rd, input int wv, output int v);
    logic a;
    logic [7:0] b;
    int n;
    n = (p == 1) ? 1 : 2;
    v = 0;
    tsr_master_inst.start();
    tsr_master_inst.wbyte({7'(`TSR_ADDR_BASE), 1'b0}, a);
    chk(16'(a), 16'h1);
    tsr_master_inst.wbyte(8'(p), a);
    chk(16'(a), 16'(p < 4));
    if (p < 4) mptr = p;
    if (rd) begin
      tsr_master_inst.start();
      tsr_master_inst.wbyte({7'(`TSR_ADDR_BASE), 1'b1}, a);
      chk(16'(a), 16'h1);
      if (mcfg[1] && ma) begin
        ma = 0;
        wu = !wu;
      end
      for (int i = 0; i < n; i++) begin
        tsr_master_inst.rbyte(i < n - 1, b);
        v = (v << 8) | b;
      end
    end else begin
      for (int i = n - 1; i >= 0; i--) begin
        tsr_master_inst.wbyte(8'(wv >> (8 * i)), a);
        chk(16'(a), 16'h1);
      end
    end
    tsr_master_inst.stop();
    repeat (8) @(posedge clk);
    pin();
  endtask
  task automatic rd(input int p);
    int v;
    reg_op(p, 1'b1, 0, v);
    chk(16'(v), 16'(mreg(mptr)));
  endtask
  task automatic wr(input int p, input int wv);
    int v;
    // Model first: the design takes the byte before the pin check inside the transfer
    // masked fields, temperature read-only
    if (p == 1) mcfg = wv & 'h1F;
    if (p == 2) mlo = wv & 'hFF80;
    if (p == 3) mhi = wv & 'hFF80;
    if (p == 1 && mcfg[0]) mtemp = 'h8000;
    reg_op(p, 1'b0, wv, v);
  endtask
  task automatic conv(input logic [12:0] d);
    logic f;
    @(posedge clk);
    cdata <= d;
    cvalid <= 1'b1;
    @(posedge clk);
    cvalid <= 1'b0;
    if (!mcfg[0]) begin
      mtemp = {d, 3'b000};
      f = ((mcfg[1] ? wu : ma) ? $signed(16'(mtemp)) < $signed(16'(mlo))
          : $signed(16'(mtemp)) > $signed(16'(mhi))) && !(mcfg[1] && ma);
      cnt = f ? cnt + 1 : 0;
      if (cnt == dep[mcfg[4:3]]) begin
        ma = mcfg[1] ? 1 : !ma;
        cnt = 0;
      end
    end
    repeat (3) @(posedge clk);
    pin();
  endtask
  task automatic reqs(input int exp);
    int v;
    v = req_cnt;
    repeat (400) @(posedge clk);
    chk(16'(req_cnt - v), 16'(exp));
  endtask
  // ==========================================
  // Scenarios
  initial begin
    logic a;
    int v;
    v = $urandom(32'h9BF0);
    for (int s = 0; s < 4; s++) begin
      do_rst(2'(s));
      for (int j = 0; j < 2; j++) begin
        tsr_master_inst.start();
        tsr_master_inst.wbyte({7'(`TSR_ADDR_BASE | (s ^ j)), 1'b0}, a);
        tsr_master_inst.stop();
        chk(16'(a), 16'(j == 0));
      end
    end
    do_rst(2'h0);
    for (int p = 0; p < 4; p++) rd(p);
    repeat (8) begin
      conv(13'($urandom));
      rd(0);
    end
    rd(3);
    rd(5);
    do_rst(2'h0);
    for (int p = 3; p >= 0; p--) wr(p, int'($urandom));
    for (int p = 0; p < 4; p++) rd(p);
    chk(16'(shdn), 16'(mcfg[0]));
    for (int q = 0; q < 4; q++) begin
      do_rst(2'h0);
      wr(1, (q << 3) | ((q & 1) << 2));
      repeat (dep[q] - 1) conv(13'h0A01);
      conv(13'h0980);
      repeat (dep[q]) conv(13'h0A01);
      repeat (dep[q]) conv(13'h0900);
    end
    do_rst(2'h0);
    wr(1, 'h0E);
    repeat (4) conv(13'h0A01);
    rd(0);
    repeat (2) conv(13'h0A01);
    repeat (2) conv(13'h0900);
    rd(1);
    repeat (2) conv(13'h0A01);
    do_rst(2'h0);
    wr(1, 'h01);
    chk(16'(shdn), 16'h1);
    rd(0);
    reqs(0);
    conv(13'h0123);
    wr(1, 'h00);
    rd(0);
    reqs(2);
    conv(13'h0123);
    rd(0);
    print_verdict();
  end
  initial begin
    repeat (95000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
endmodule // tsr_top_tb
`default_nettype wire

// [logic/tsr_alarm.sv]
`include "tsr_consts.svh"
`default_nettype none
module tsr_alarm (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic conv_i,
  input wire logic [15:0] temp_i,
  input wire logic [8:0] upper_temp_limit_i,
  input wire logic [8:0] lower_temp_limit_i,
  input wire tsr_pkg::tsr_cfg_s cfg_i,
  input wire logic rd_i,
  output logic alarm_o
);
  import tsr_pkg::*;

  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic act_ff;
  logic watch_low_ff;
  logic [2:0] cnt_ff;

  wire over = $signed(temp_i) > $signed({upper_temp_limit_i, 7'h00});
  wire under = $signed(temp_i) < $signed({lower_temp_limit_i, 7'h00});
  wire [2:0] depth = (cfg_i.fq == 2'h0) ? `TSR_FQ_D0 :
                     (cfg_i.fq == 2'h1) ? `TSR_FQ_D1 :
                     (cfg_i.fq == 2'h2) ? `TSR_FQ_D2 : `TSR_FQ_D3;
  wire look_low = cfg_i.mode ? watch_low_ff : act_ff;
  wire fault = look_low ? under : over;
  // Interrupt alarm stops counting until software reads
  wire hold = cfg_i.mode & act_ff;
  wire hit = conv_i & fault & ~hold & (cnt_ff == depth - 3'h1);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= 3'h0;
    end else if (conv_i & ~hold) begin
      cnt_ff <= (hit | ~fault) ? 3'h0 : cnt_ff + 3'h1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_ff <= 1'b0;
      watch_low_ff <= 1'b0;
    end else if (hit) begin
      act_ff <= ~act_ff;
    end else if (hold & rd_i) begin
      act_ff <= 1'b0;
      watch_low_ff <= ~watch_low_ff;
    end
  end

  // polarity on the pin; idle high matches reset polarity
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      alarm_o <= 1'b1;
    end else begin
      alarm_o <= ~(act_ff ^ cfg_i.pol);
    end
  end

  pol_high_a: assert property (act_ff && cfg_i.pol && $stable(cfg_i.pol) |=> alarm_o)
    else $error("alarm pin not high for active-high alarm");
  queue_depth_a: assert property ($rose(act_ff) |-> $past(cnt_ff) == $past(depth) - 3'h1)
    else $error("alarm rose before fault queue filled");
  comp_set_a: assert property (!cfg_i.mode && $rose(act_ff) |-> $past(over) && $past(conv_i))
    else $error("comparator alarm set without over-limit conversion");
  comp_clear_a: assert property (!cfg_i.mode && $fell(act_ff) |-> $past(under) && $past(conv_i))
    else $error("comparator alarm cleared without under-limit conversion");
  int_hold_a: assert property (cfg_i.mode && act_ff && !rd_i && $stable(cfg_i) |=> act_ff)
    else $error("interrupt alarm dropped without a read");
  read_flip_a: assert property (cfg_i.mode && act_ff && rd_i |=> !act_ff ##0 watch_low_ff != $past(watch_low_ff))
    else $error("read did not clear alarm and flip watched fault");

endmodule // tsr_alarm
`default_nettype wire

// [logic/tsr_consts.svh]
`ifndef TSR_CONSTS_SVH
`define TSR_CONSTS_SVH

// ==========================================
// Slave addressing
`define TSR_ADDR_BASE 7'h48

// ==========================================
// Register select codes
`define TSR_PTR_TEMP 2'h0
`define TSR_PTR_CFG 2'h1
`define TSR_PTR_LOWER_TEMP_LIMIT 2'h2
`define TSR_PTR_UPPER_TEMP_LIMIT 2'h3

// ==========================================
// Reset and forced values
`define TSR_CFG_RST 5'h00
`define TSR_UPPER_TEMP_LIMIT_RST 9'h0A0
`define TSR_LOWER_TEMP_LIMIT_RST 9'h096
`define TSR_TEMP_RST 13'h0000
`define TSR_TEMP_SHDN 16'h8000

// ==========================================
// Fault queue depths per code
`define TSR_FQ_D0 3'h1
`define TSR_FQ_D1 3'h2
`define TSR_FQ_D2 3'h4
`define TSR_FQ_D3 3'h6

// ==========================================
// Conversion timebase
`define TSR_CONV_MS 133
`define TSR_CLK_KHZ 100000

`endif

// [logic/tsr_pkg.sv]
`default_nettype none
package tsr_pkg;

  // Bus phases, Gray steps along the usual path
  typedef enum logic [2:0] {
    TSR_IDLE = 3'h0,
    TSR_ADDR = 3'h1,
    TSR_AACK = 3'h3,
    TSR_RX = 3'h2,
    TSR_RXACK = 3'h6,
    TSR_TX = 3'h7,
    TSR_TXACK = 3'h5
  } tsr_state_e;

  // Filtered pin with its edges
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } tsr_line_s;

  // Configuration fields, packed in register bit order
  typedef struct packed {
    logic [1:0] fq;
    logic pol;
    logic mode;
    logic shdn;
  } tsr_cfg_s;

endpackage
`default_nettype wire

// [logic/tsr_sync.sv]
`default_nettype none
module tsr_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output var tsr_pkg::tsr_line_s line_o
);
  import tsr_pkg::*;

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic lvl_ff;

  // Idle bus is high, so all stages reset high
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
      lvl_ff <= 1'b1;
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        lvl_ff <= s3_ff;
      end
    end
  end

  wire agree_hi = s2_ff & s3_ff;
  wire agree_lo = ~s2_ff & ~s3_ff;

  // Edge pulses lead the level by one cycle
  assign line_o = '{level: lvl_ff, rise: agree_hi & ~lvl_ff, fall: agree_lo & lvl_ff};

endmodule // tsr_sync
`default_nettype wire

// [logic/tsr_top.sv]
`include "tsr_consts.svh"
`default_nettype none
// ==========================================
module tsr_top #(
  parameter int unsigned CONV_CYCLES = `TSR_CONV_MS * `TSR_CLK_KHZ
) (
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic [1:0] ADDR_SEL_I,
  input wire logic [12:0] CONV_DATA_I,
  input wire logic CONV_VALID_I,
  output logic SDA_O,
  output logic SDA_OE_N_O,
  output logic CONV_REQ_O,
  output logic SHUTDOWN_O,
  output logic OVERTEMP_ALARM_OUT_O
);
  import tsr_pkg::*;

  default clocking @(posedge CLK_SYS_I);
  endclocking
  default disable iff (SYS_RST_I);

  localparam logic [23:0] CONV_LAST = 24'(CONV_CYCLES - 1);

  // ==========================================
  // Pin conditioning
  tsr_line_s scl_ln;
  tsr_line_s sda_ln;

  tsr_sync u_scl_sync (
    .clk_i(CLK_SYS_I),
    .rst_i(SYS_RST_I),
    .pin_i(SCL_I),
    .line_o(scl_ln)
  );

  tsr_sync u_sda_sync (
    .clk_i(CLK_SYS_I),
    .rst_i(SYS_RST_I),
    .pin_i(SDA_I),
    .line_o(sda_ln)
  );

  wire start_det = sda_ln.fall & scl_ln.level;
  wire stop_det = sda_ln.rise & scl_ln.level;

  // ==========================================
  // State
  tsr_state_e state_ff;
  tsr_state_e nxt_state;
  logic [3:0] bit_cnt_ff;
  logic [3:0] nxt_bit_cnt;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic [1:0] byte_idx_ff;
  logic [1:0] nxt_byte_idx;
  logic rw_ff;
  logic nxt_rw;
  logic sda_oe_n_ff;
  logic nxt_sda_oe_n;
  logic rd_evt;
  logic wr_evt;
  logic [1:0] addr_sel_ff;
  logic addr_taken_ff;
  logic [1:0] ptr_ff;
  tsr_cfg_s cfg_ff;
  logic [8:0] upper_temp_limit_ff;
  logic [8:0] lower_temp_limit_ff;
  logic [12:0] temp_ff;
  logic [23:0] conv_cnt_ff;
  logic conv_req_ff;

  // ==========================================
  // Decode and read selection
  wire [6:0] dev_addr = `TSR_ADDR_BASE | {5'h00, addr_sel_ff};
  wire addr_hit = (shift_ff[7:1] == dev_addr);
  wire ptr_ok = (shift_ff[7:2] == 6'h00);
  wire rx_ack = (byte_idx_ff != 2'h0) | ptr_ok;
  wire [15:0] shdn_word = `TSR_TEMP_SHDN;
  wire [15:0] temp_word = {temp_ff, 3'h0};
  wire [15:0] upper_temp_limit_word = {upper_temp_limit_ff, 7'h00};
  wire [15:0] lower_temp_limit_word = {lower_temp_limit_ff, 7'h00};
  wire [15:0] sel_word = (ptr_ff == `TSR_PTR_TEMP) ? temp_word :
                         (ptr_ff == `TSR_PTR_LOWER_TEMP_LIMIT) ? lower_temp_limit_word : upper_temp_limit_word;
  wire is_cfg = (ptr_ff == `TSR_PTR_CFG);
  wire [7:0] tx_byte = is_cfg ? {3'h0, cfg_ff} :
                       (byte_idx_ff[0] ? sel_word[7:0] : sel_word[15:8]);
  wire [1:0] idx_sat = (byte_idx_ff == 2'h3) ? 2'h3 : byte_idx_ff + 2'h1;
  wire conv_take = CONV_VALID_I & ~cfg_ff.shdn;

  // ==========================================
  // Serial slave sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift = shift_ff;
    nxt_byte_idx = byte_idx_ff;
    nxt_rw = rw_ff;
    nxt_sda_oe_n = sda_oe_n_ff;
    rd_evt = 1'b0;
    wr_evt = 1'b0;
    if (stop_det) begin
      nxt_state = TSR_IDLE;
      nxt_sda_oe_n = 1'b1;
    end else if (start_det) begin
      nxt_state = TSR_ADDR;
      nxt_bit_cnt = 4'h0;
      nxt_byte_idx = 2'h0;
      nxt_sda_oe_n = 1'b1;
    end else if (scl_ln.rise) begin
      case (state_ff)
        TSR_ADDR, TSR_RX: begin
          nxt_shift = {shift_ff[6:0], sda_ln.level};
          nxt_bit_cnt = bit_cnt_ff + 4'h1;
        end
        TSR_TXACK: begin
          // Master not-acknowledge ends the read
          if (sda_ln.level) begin
            nxt_state = TSR_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_ln.fall) begin
      case (state_ff)
        TSR_ADDR: begin
          if (bit_cnt_ff == 4'h8) begin
            nxt_state = addr_hit ? TSR_AACK : TSR_IDLE;
            nxt_sda_oe_n = ~addr_hit;
            nxt_rw = shift_ff[0];
          end
        end
        TSR_AACK: begin
          nxt_bit_cnt = 4'h0;
          if (rw_ff) begin
            nxt_state = TSR_TX;
            nxt_shift = tx_byte;
            nxt_sda_oe_n = tx_byte[7];
            rd_evt = 1'b1;
          end else begin
            nxt_state = TSR_RX;
            nxt_sda_oe_n = 1'b1;
          end
        end
        TSR_RX: begin
          if (bit_cnt_ff == 4'h8) begin
            nxt_state = TSR_RXACK;
            nxt_sda_oe_n = ~rx_ack;
            wr_evt = 1'b1;
          end
        end
        TSR_RXACK: begin
          nxt_state = TSR_RX;
          nxt_sda_oe_n = 1'b1;
          nxt_bit_cnt = 4'h0;
          nxt_byte_idx = idx_sat;
        end
        TSR_TX: begin
          if (bit_cnt_ff == 4'h7) begin
            nxt_state = TSR_TXACK;
            nxt_sda_oe_n = 1'b1;
            nxt_byte_idx = {1'b0, ~byte_idx_ff[0]};
          end else begin
            nxt_shift = {shift_ff[6:0], 1'b0};
            nxt_sda_oe_n = shift_ff[6];
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end
        end
        TSR_TXACK: begin
          nxt_state = TSR_TX;
          nxt_shift = tx_byte;
          nxt_sda_oe_n = tx_byte[7];
          nxt_bit_cnt = 4'h0;
        end
        default: begin
          nxt_state = TSR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state_ff <= TSR_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      byte_idx_ff <= 2'h0;
      rw_ff <= 1'b0;
      sda_oe_n_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      byte_idx_ff <= nxt_byte_idx;
      rw_ff <= nxt_rw;
      sda_oe_n_ff <= nxt_sda_oe_n;
    end
  end

  // Strap is caught once, after reset release
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      addr_sel_ff <= 2'h0;
      addr_taken_ff <= 1'b0;
    end else if (!addr_taken_ff) begin
      addr_sel_ff <= ADDR_SEL_I;
      addr_taken_ff <= 1'b1;
    end
  end

  // ==========================================
  // Register writes
  // pointer kept until rewritten
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ptr_ff <= `TSR_PTR_TEMP;
    end else if (wr_evt && byte_idx_ff == 2'h0 && ptr_ok) begin
      ptr_ff <= shift_ff[1:0];
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cfg_ff <= `TSR_CFG_RST;
    end else if (wr_evt && byte_idx_ff == 2'h1 && is_cfg) begin
      cfg_ff <= shift_ff[4:0];
    end
  end

  // limits, low seven bits not stored
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      upper_temp_limit_ff <= `TSR_UPPER_TEMP_LIMIT_RST;
      lower_temp_limit_ff <= `TSR_LOWER_TEMP_LIMIT_RST;
    end else if (wr_evt && byte_idx_ff == 2'h1) begin
      if (ptr_ff == `TSR_PTR_UPPER_TEMP_LIMIT) upper_temp_limit_ff[8:1] <= shift_ff;
      if (ptr_ff == `TSR_PTR_LOWER_TEMP_LIMIT) lower_temp_limit_ff[8:1] <= shift_ff;
    end else if (wr_evt && byte_idx_ff == 2'h2) begin
      if (ptr_ff == `TSR_PTR_UPPER_TEMP_LIMIT) upper_temp_limit_ff[0] <= shift_ff[7];
      if (ptr_ff == `TSR_PTR_LOWER_TEMP_LIMIT) lower_temp_limit_ff[0] <= shift_ff[7];
    end
  end

  // ==========================================
  // Conversion result and timebase
  // temperature word
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      temp_ff <= `TSR_TEMP_RST;
    end else if (cfg_ff.shdn) begin
      temp_ff <= shdn_word[15:3];
    end else if (conv_take) begin
      temp_ff <= CONV_DATA_I;
    end
  end

  // Shutdown stops the conversion requests outright
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      conv_cnt_ff <= 24'h000000;
      conv_req_ff <= 1'b0;
    end else if (cfg_ff.shdn) begin
      conv_cnt_ff <= 24'h000000;
      conv_req_ff <= 1'b0;
    end else begin
      conv_req_ff <= (conv_cnt_ff == CONV_LAST);
      conv_cnt_ff <= (conv_cnt_ff == CONV_LAST) ? 24'h000000 : conv_cnt_ff + 24'h000001;
    end
  end

  // ==========================================
  // Alarm
  tsr_alarm u_alarm (
    .clk_i(CLK_SYS_I),
    .rst_i(SYS_RST_I),
    .conv_i(conv_take),
    .temp_i({CONV_DATA_I, 3'h0}),
    .upper_temp_limit_i(upper_temp_limit_ff),
    .lower_temp_limit_i(lower_temp_limit_ff),
    .cfg_i(cfg_ff),
    .rd_i(rd_evt),
    .alarm_o(OVERTEMP_ALARM_OUT_O)
  );

  // Open drain: the pin is only ever pulled low
  assign SDA_O = 1'b0;
  assign SDA_OE_N_O = sda_oe_n_ff;
  assign CONV_REQ_O = conv_req_ff;
  assign SHUTDOWN_O = cfg_ff.shdn;

  // ==========================================
  // Checks
  sequence rx_slot_s;
    state_ff == TSR_RX && scl_ln.fall && bit_cnt_ff == 4'h8 && !stop_det && !start_det;
  endsequence
  sequence ack_done_s;
    state_ff == TSR_RXACK && sda_oe_n_ff == !$past(rx_ack);
  endsequence

  shdn_temp_a: assert property (cfg_ff.shdn |=> temp_ff == shdn_word[15:3])
    else $error("temperature not forced during shutdown");
  ptr_hold_a: assert property (state_ff == TSR_IDLE |=> $stable(ptr_ff))
    else $error("pointer changed outside a transfer");
  ptr_refuse_a: assert property (wr_evt && byte_idx_ff == 2'h0 && !ptr_ok |=> $stable(ptr_ff))
    else $error("pointer took a byte with upper bits set");
  addr_miss_a: assert property (state_ff == TSR_ADDR && scl_ln.fall && bit_cnt_ff == 4'h8 && !addr_hit
    && !stop_det && !start_det |=> state_ff == TSR_IDLE && sda_oe_n_ff)
    else $error("foreign address acknowledged");
  rx_ack_a: assert property (rx_slot_s |=> ack_done_s)
    else $error("received byte not followed by ack slot");
  tx_msb_a: assert property (state_ff == TSR_AACK && rw_ff && scl_ln.fall && !stop_det && !start_det
    |=> state_ff == TSR_TX && sda_oe_n_ff == $past(tx_byte[7]))
    else $error("read byte did not start with its top bit");
  temp_hold_a: assert property (!cfg_ff.shdn && !CONV_VALID_I && !$past(cfg_ff.shdn) |=> $stable(temp_ff))
    else $error("temperature changed without a conversion");

endmodule // tsr_top
`default_nettype wire
